// ==== design/ccrs_pkg.sv ====
package ccrs_pkg;
  // Reset vector words and memory regions
  localparam logic [31:0] VEC_SP_ADDR   = 32'h0000_0000;
  localparam logic [31:0] VEC_PC_ADDR   = 32'h0000_0004;
  localparam logic [31:0] CODE_BASE     = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
  localparam logic [31:0] PERI_BASE     = 32'h4000_0000;
  localparam logic [31:0] PPB_BASE      = 32'hE000_0000;
  localparam int          RGN_MSB       = 31;
  localparam int          RGN_LSB       = 29;
  localparam int          PPB_LSB       = 20;
  // Register indices and widths
  localparam int          NUM_GPR       = 13;
  localparam int          LO_REGS       = 8;
  localparam logic [3:0]  IDX_SP        = 4'hD;
  localparam logic [3:0]  IDX_LR        = 4'hE;
  localparam logic [3:0]  IDX_PC        = 4'hF;
  localparam logic [31:0] PC_STEP       = 32'h0000_0002;
  // Status word layout
  localparam int          FLAG_MSB      = 31;
  localparam int          FLAG_LSB      = 28;
  localparam int          TBIT_POS      = 24;
  localparam int          EXC_W         = 6;
  localparam int          MASK_POS      = 0;
  localparam int          CTRL_SP_POS   = 1;
  localparam int          LINK_SP_POS   = 2;
  localparam logic        MASK_RST      = 1'h0;
  localparam logic        CTRL_RST      = 1'h0;
  localparam logic [31:0] EXC_LINK_BASE = 32'hFFFF_FFF1;
  // Exception numbers
  localparam logic [5:0]  EXC_THREAD    = 6'h00;
  localparam logic [5:0]  EXC_NMI       = 6'h02;
  localparam logic [5:0]  EXC_HARD      = 6'h03;
  localparam logic [5:0]  EXC_SVC       = 6'h0B;
  localparam logic [5:0]  EXC_PSV       = 6'h0E;
  localparam logic [5:0]  EXC_TICK      = 6'h0F;
  localparam logic [5:0]  EXC_IRQ0      = 6'h10;
  localparam logic [5:0]  EXC_IRQ_LAST  = 6'h23;

  typedef enum logic [3:0] {
    OP_NONE, OP_WR, OP_MUL, OP_FLAGS, OP_BX, OP_CALL,
    OP_MSR, OP_CPSID, OP_CPSIE, OP_EXC_IN, OP_EXC_OUT
  } ccrs_op_e;
  typedef enum logic [1:0] {SYS_FLAGS, SYS_MASK, SYS_CTRL} ccrs_sys_e;
  typedef enum logic [2:0] {
    ST_BOOT_SP = 3'h1,
    ST_BOOT_PC = 3'h2,
    ST_RUN     = 3'h4
  } ccrs_st_e;
  typedef enum logic [2:0] {RG_CODE, RG_SRAM, RG_PERI, RG_NONE, RG_PPB, RG_VEND} ccrs_rgn_e;
  typedef struct packed {
    ccrs_op_e    kind;
    logic [3:0]  rd;
    logic [3:0]  rn;
    logic [3:0]  rm;
    logic        set_flags;
    ccrs_sys_e   sys;
    logic [3:0]  nzcv;
    logic [5:0]  exc;
    logic [31:0] data;
  } ccrs_op_s;
endpackage

// ==== design/ccrs_core.sv ====
// What this block does
// - Code region at address zero holds program, data and the vector table.
// - Region from 0x20000000 is data memory and allows instruction fetch.
// - Peripheral region from 0x40000000 refuses instruction fetch.
// - Core-internal peripheral region starts at 0xE0000000.
// - Sixteen 32-bit registers; registers 8 to 12 only reachable by some ops.
// - Two banked stack pointers behind register 13, one visible at a time.
// - Stack select 0 picks main pointer, 1 process pointer; resets to 0.
// - Register 14 takes return information on calls and exception entry.
// - Reset loads word at 0x00000004 into program counter, bit 0 into state bit.
// - Writing register 15 redirects program flow to the written address.
// - Status bits 31 to 28 hold negative, zero, carry and overflow flags.
// - State bit 24 must be 1; executing with it clear raises hard fault.
// - Status bits 5 to 0 carry the active exception number.
// - Exception number and execution state are read-only; number resets to 0.
// - Mask bit set blocks all configurable-priority exceptions; resets to 0.
// - Mask changes only by special-register move or change-state ops.
// - Instructions run through a two-stage pipeline.
// - A 32 by 32 multiply gives its 32-bit result in one cycle.
// - Stack select sits in control bit 1; handler mode always uses main.
// - Handler mode ignores software writes to control register.
`timescale 1ns/100ps
`default_nettype none
module ccrs_core (
  input  wire logic               clk,
  input  wire logic               nrst,
  output logic                    vec_req,
  output logic [31:0]             vec_addr,
  input  wire logic [31:0]        vec_rdata,
  input  wire logic               vec_ack,
  output logic                    core_ready,
  input  wire logic               op_valid,
  input  wire ccrs_pkg::ccrs_op_s op,
  output logic                    res_valid,
  output logic [31:0]             res_data,
  output logic                    fault_pulse,
  output logic [31:0]             status_word,
  output logic [31:0]             pc_out,
  output logic [31:0]             msp_out,
  output logic [31:0]             psp_out,
  output logic [31:0]             lr_out,
  output logic                    mask_out,
  output logic                    sp_sel_out,
  input  wire logic               exc_req,
  input  wire logic [5:0]         exc_num,
  output logic                    exc_take,
  input  wire logic               acc_valid,
  input  wire logic [31:0]        acc_addr,
  input  wire logic               acc_fetch,
  output ccrs_pkg::ccrs_rgn_e     acc_region,
  output logic                    acc_fault
);
  import ccrs_pkg::*;

  ccrs_st_e    state_q;
  logic        vreq_q;
  logic [31:0] vaddr_q;
  logic        opq_v;
  ccrs_op_s    opq;
  logic [31:0] gpr_q [NUM_GPR];
  logic [31:0] msp_q;
  logic [31:0] psp_q;
  logic [31:0] lr_q;
  logic [31:0] pc_q;
  logic        tbit_q;
  logic [3:0]  flags_q;
  logic [5:0]  active_exception_number_q;
  logic        mask_q;
  logic        ctrl_q;
  logic        resv_q;
  logic [31:0] res_q;
  logic        fault_q;
  logic        take_q;
  ccrs_rgn_e   rgn_q;
  logic        afault_q;

  logic        run;
  logic        handler;
  logic        use_psp;
  logic        exe;
  logic        exc_in_ok;
  logic        wb_en;
  logic [3:0]  wb_idx;
  logic [31:0] wb_val;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [63:0] prod;

  // Handler mode forces the main pointer whatever control says
  function automatic logic [31:0] rd_reg(input logic [3:0] i);
    case (i)
      IDX_SP:  rd_reg = use_psp ? psp_q : msp_q;
      IDX_LR:  rd_reg = lr_q;
      IDX_PC:  rd_reg = pc_q;
      default: rd_reg = gpr_q[i];
    endcase
  endfunction

  function automatic logic exc_ok(input logic [5:0] n, input logic m);
    exc_ok = (n == EXC_NMI) || (n == EXC_HARD) || !m;
  endfunction

  function automatic ccrs_rgn_e rgn(input logic [31:0] a);
    if (a[RGN_MSB:RGN_LSB] == CODE_BASE[RGN_MSB:RGN_LSB]) begin
      rgn = RG_CODE;
    end else if (a[RGN_MSB:RGN_LSB] == SRAM_BASE[RGN_MSB:RGN_LSB]) begin
      rgn = RG_SRAM;
    end else if (a[RGN_MSB:RGN_LSB] == PERI_BASE[RGN_MSB:RGN_LSB]) begin
      rgn = RG_PERI;
    end else if (a[RGN_MSB:PPB_LSB] == PPB_BASE[RGN_MSB:PPB_LSB]) begin
      rgn = RG_PPB;
    end else if (a[RGN_MSB:RGN_LSB] == PPB_BASE[RGN_MSB:RGN_LSB]) begin
      rgn = RG_VEND;
    end else begin
      rgn = RG_NONE;
    end
  endfunction

  assign run     = (state_q == ST_RUN);
  assign handler = (active_exception_number_q != EXC_THREAD);
  assign use_psp = ctrl_q && !handler;
  assign exe     = opq_v && tbit_q && (opq.kind != OP_NONE);
  assign exc_in_ok = exc_ok(opq.exc, mask_q);

  // multiply on low registers, one cycle
  always_comb begin
    opa    = rd_reg({1'b0, opq.rn[2:0]});
    opb    = rd_reg({1'b0, opq.rm[2:0]});
    prod   = opa * opb;
    wb_en  = exe && (opq.kind == OP_WR || opq.kind == OP_MUL);
    wb_idx = (opq.kind == OP_MUL) ? {1'b0, opq.rd[2:0]} : opq.rd;
    wb_val = (opq.kind == OP_MUL) ? prod[31:0] : opq.data;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_BOOT_SP;
      vreq_q  <= 1'b1;
      vaddr_q <= VEC_SP_ADDR;
    end else begin
      case (state_q)
        ST_BOOT_SP: begin
          if (vec_ack) begin
            state_q <= ST_BOOT_PC;
            vaddr_q <= VEC_PC_ADDR;
          end
        end
        ST_BOOT_PC: begin
          if (vec_ack) begin
            state_q <= ST_RUN;
            vreq_q  <= 1'b0;
          end
        end
        ST_RUN: begin
          vreq_q <= 1'b0;
        end
        default: begin
          state_q <= ST_BOOT_SP;
          vreq_q  <= 1'b1;
          vaddr_q <= VEC_SP_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opq_v <= 1'b0;
      opq   <= '0;
    end else begin
      opq_v <= op_valid && run;
      opq   <= op;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_q[i] <= '0;
      end
    end else if (wb_en && wb_idx < IDX_SP) begin
      gpr_q[wb_idx] <= wb_val;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      msp_q <= '0;
    end else if (state_q == ST_BOOT_SP && vec_ack) begin
      msp_q <= vec_rdata;
    end else if (wb_en && wb_idx == IDX_SP && !use_psp) begin
      msp_q <= wb_val;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      psp_q <= '0;
    end else if (wb_en && wb_idx == IDX_SP && use_psp) begin
      psp_q <= wb_val;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lr_q <= '0;
    end else if (wb_en && wb_idx == IDX_LR) begin
      lr_q <= wb_val;
    end else if (exe && opq.kind == OP_CALL) begin
      lr_q <= (pc_q + PC_STEP) | 32'h0000_0001;
    end else if (exe && opq.kind == OP_EXC_IN && exc_in_ok) begin
      lr_q <= EXC_LINK_BASE | {29'h0, use_psp, 2'h0};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_q <= '0;
    end else if (state_q == ST_BOOT_PC && vec_ack) begin
      pc_q <= vec_rdata & ~32'h0000_0001;
    end else if (wb_en && wb_idx == IDX_PC) begin
      pc_q <= wb_val & ~32'h0000_0001;
    end else if (exe && (opq.kind == OP_BX || opq.kind == OP_CALL ||
                         opq.kind == OP_EXC_OUT ||
                         (opq.kind == OP_EXC_IN && exc_in_ok))) begin
      pc_q <= opq.data & ~32'h0000_0001;
    end else if (exe) begin
      pc_q <= pc_q + PC_STEP;
    end
  end

  // state bit only from vectors and branches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tbit_q <= 1'b0;
    end else if (state_q == ST_BOOT_PC && vec_ack) begin
      tbit_q <= vec_rdata[0];
    end else if (exe && (opq.kind == OP_BX ||
                         (opq.kind == OP_EXC_IN && exc_in_ok))) begin
      tbit_q <= opq.data[0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
    end else if (exe && opq.kind == OP_FLAGS) begin
      flags_q <= opq.nzcv;
    end else if (exe && opq.kind == OP_MSR && opq.sys == SYS_FLAGS) begin
      flags_q <= opq.data[FLAG_MSB:FLAG_LSB];
    end else if (wb_en && opq.set_flags) begin
      flags_q <= {wb_val[31], wb_val == 32'h0, flags_q[1:0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_exception_number_q <= EXC_THREAD;
    end else if (exe && opq.kind == OP_EXC_IN && exc_in_ok) begin
      active_exception_number_q <= opq.exc;
    end else if (exe && opq.kind == OP_EXC_OUT) begin
      active_exception_number_q <= EXC_THREAD;
    end
  end

  // mask only by move or change-state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= MASK_RST;
    end else if (exe && opq.kind == OP_MSR && opq.sys == SYS_MASK) begin
      mask_q <= opq.data[MASK_POS];
    end else if (exe && opq.kind == OP_CPSID) begin
      mask_q <= 1'b1;
    end else if (exe && opq.kind == OP_CPSIE) begin
      mask_q <= 1'b0;
    end
  end

  // stack select, frozen to software in handler mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
    end else if (exe && opq.kind == OP_MSR && opq.sys == SYS_CTRL && !handler) begin
      ctrl_q <= opq.data[CTRL_SP_POS];
    end else if (exe && opq.kind == OP_EXC_OUT) begin
      ctrl_q <= lr_q[LINK_SP_POS];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resv_q  <= 1'b0;
      res_q   <= '0;
      fault_q <= 1'b0;
      take_q  <= 1'b0;
    end else begin
      resv_q  <= wb_en;
      res_q   <= wb_en ? wb_val : res_q;
      fault_q <= opq_v && !tbit_q && (opq.kind != OP_NONE);
      take_q  <= run && exc_req && exc_ok(exc_num, mask_q);
    end
  end

  // region decode, fetch only from code or data memory
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rgn_q    <= RG_CODE;
      afault_q <= 1'b0;
    end else begin
      rgn_q    <= rgn(acc_addr);
      afault_q <= acc_valid && acc_fetch &&
                  !(rgn(acc_addr) == RG_CODE || rgn(acc_addr) == RG_SRAM);
    end
  end

  assign vec_req     = vreq_q;
  assign vec_addr    = vaddr_q;
  assign core_ready  = run;
  assign res_valid   = resv_q;
  assign res_data    = res_q;
  assign fault_pulse = fault_q;
  assign status_word = {flags_q, 3'h0, tbit_q, 18'h0, active_exception_number_q};
  assign pc_out      = pc_q;
  assign msp_out     = msp_q;
  assign psp_out     = psp_q;
  assign lr_out      = lr_q;
  assign mask_out    = mask_q;
  assign sp_sel_out  = ctrl_q;
  assign exc_take    = take_q;
  assign acc_region  = rgn_q;
  assign acc_fault   = afault_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_boot_sp: assert property (
    state_q == ST_BOOT_SP && vec_ack |=> msp_q == $past(vec_rdata) && state_q == ST_BOOT_PC)
    else $error("main stack pointer not loaded from vector zero");
  chk_boot_pc: assert property (
    state_q == ST_BOOT_PC && vec_ack |=> tbit_q == $past(vec_rdata[0]) && run)
    else $error("state bit not loaded from reset vector");
  chk_mask_block: assert property (
    exc_req && mask_q && exc_num > EXC_HARD |=> !exc_take)
    else $error("masked exception was taken");
  chk_nmi_pass: assert property (
    run && exc_req && exc_num == EXC_NMI |=> exc_take)
    else $error("non-maskable exception refused");
  chk_ctrl_handler: assert property (
    exe && opq.kind == OP_MSR && opq.sys == SYS_CTRL && handler |=> $stable(ctrl_q))
    else $error("control written in handler mode");
  chk_tbit_fault: assert property (
    opq_v && !tbit_q && opq.kind != OP_NONE |=> fault_pulse && $stable(pc_q))
    else $error("execution with state bit clear");
  chk_mul_lat: assert property (
    op_valid && run && tbit_q && op.kind == OP_MUL && opq.kind != OP_BX |=> ##1 res_valid)
    else $error("multiply result late");
  chk_pc_redirect: assert property (
    wb_en && wb_idx == IDX_PC |=> pc_q == ($past(wb_val) & ~32'h0000_0001))
    else $error("program counter not redirected");
  chk_fetch_peri: assert property (
    acc_valid && acc_fetch && acc_addr[RGN_MSB:RGN_LSB] == PERI_BASE[RGN_MSB:RGN_LSB]
    |=> acc_fault && acc_region == RG_PERI)
    else $error("fetch from peripheral region allowed");
  chk_active_exception_number_ro: assert property (
    exe && opq.kind == OP_MSR |=> $stable(active_exception_number_q))
    else $error("exception number written by software");

  cov_boot: cover property (state_q == ST_BOOT_PC ##1 run);
  cov_exc_in: cover property (exe && opq.kind == OP_EXC_IN && exc_in_ok);
  cov_mul: cover property (exe && opq.kind == OP_MUL);
  cov_fault: cover property (fault_pulse);
endmodule
`default_nettype wire

// ==== dv/ccrs_vec_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccrs_vec_mem #(
  parameter int          LAT     = 2,
  parameter logic [31:0] SP_WORD = 32'h2000_1000,
  parameter logic [31:0] PC_WORD = 32'h0000_0101
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        vec_req,
  input  wire logic [31:0] vec_addr,
  output logic [31:0]      vec_rdata,
  output logic             vec_ack
);
  import ccrs_pkg::*;
  int wait_q;
  // vector words
  // Word is valid only in the ack cycle; scrambled otherwise so a late sample shows
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q    <= 0;
      vec_ack   <= 1'b0;
      vec_rdata <= 32'hA5A5_5A5A;
    end else if (vec_req && !vec_ack && wait_q == LAT) begin
      wait_q    <= 0;
      vec_ack   <= 1'b1;
      vec_rdata <= (vec_addr === VEC_PC_ADDR) ? PC_WORD : SP_WORD;
    end else begin
      vec_ack   <= 1'b0;
      vec_rdata <= ~vec_rdata;
      if (vec_req && !vec_ack) begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/ccrs_core_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module ccrs_core_test;
  import ccrs_pkg::*;
  localparam logic [31:0] SP_W = 32'h2000_1000;
  localparam logic [31:0] PC_W = 32'h0000_0101;
  logic        clk, nrst, vec_req, vec_ack, core_ready, op_valid, res_valid;
  logic        fault_pulse, mask_out, sp_sel_out, exc_req, exc_take;
  logic        acc_valid, acc_fetch, acc_fault, early_rv;
  logic [31:0] vec_addr, vec_rdata, res_data, status_word, pc_out;
  logic [31:0] msp_out, psp_out, lr_out, acc_addr;
  logic [5:0]  exc_num;
  ccrs_op_s    op;
  ccrs_rgn_e   acc_region;
  int          n_fail;
  int          comparisons;

  ccrs_core i_dut (.clk(clk), .nrst(nrst), .vec_req(vec_req), .vec_addr(vec_addr),
    .vec_rdata(vec_rdata), .vec_ack(vec_ack), .core_ready(core_ready), .op_valid(op_valid),
    .op(op), .res_valid(res_valid), .res_data(res_data), .fault_pulse(fault_pulse),
    .status_word(status_word), .pc_out(pc_out), .msp_out(msp_out), .psp_out(psp_out),
    .lr_out(lr_out), .mask_out(mask_out), .sp_sel_out(sp_sel_out), .exc_req(exc_req),
    .exc_num(exc_num), .exc_take(exc_take), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_fetch(acc_fetch), .acc_region(acc_region), .acc_fault(acc_fault));

  ccrs_vec_mem #(.LAT(2), .SP_WORD(SP_W), .PC_WORD(PC_W)) i_vec (.clk(clk), .nrst(nrst),
    .vec_req(vec_req), .vec_addr(vec_addr), .vec_rdata(vec_rdata), .vec_ack(vec_ack));

  always #12.5 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reset, then wait for both vector words under a bound
  task automatic do_reset();
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 40 && core_ready !== 1'b1; i++) @(negedge clk);
    if (core_ready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask

  // For MOVE_TO_SPECIAL_REG the rd field carries the special-register select
  task automatic run_op(input ccrs_op_e k, input logic [3:0] rd, input logic [5:0] ex,
                        input logic [31:0] d);
    op = '{kind: k, rd: rd, rn: 4'h1, rm: 4'h2, set_flags: 1'b1,
           sys: ccrs_sys_e'(rd[1:0]), nzcv: d[31:28], exc: ex, data: d};
    op_valid = 1'b1;
    @(negedge clk);
    early_rv = res_valid;
    op_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_boot();
    chk_word(msp_out, SP_W);
    chk_word(pc_out, 32'h0000_0100);
    chk_word(status_word, 32'h0100_0000);
    chk_bit(mask_out, 1'b0);
    chk_bit(sp_sel_out, 1'b0);
    chk_bit(vec_req, 1'b0);
    chk_word(vec_addr, VEC_PC_ADDR);
  endtask

  task automatic t_regs();
    run_op(OP_FLAGS, 4'h0, 6'h00, 32'hF000_0000);
    chk_word({28'h0, status_word[31:28]}, 32'hF);
    run_op(OP_WR, 4'h1, 6'h00, 32'h0001_0000);
    chk_word(res_data, 32'h0001_0000);
    run_op(OP_WR, 4'h2, 6'h00, 32'h0001_0000);
    run_op(OP_MUL, 4'h3, 6'h00, 32'h0);
    chk_bit(early_rv, 1'b0);
    chk_bit(res_valid, 1'b1);
    chk_word(res_data, 32'h0);
    chk_word({30'h0, status_word[31:30]}, 32'h1);
    run_op(OP_WR, IDX_PC, 6'h00, 32'h0000_0400);
    chk_word(pc_out, 32'h0000_0400);
    run_op(OP_CALL, 4'h0, 6'h00, 32'h0000_0800);
    chk_word(lr_out, 32'h0000_0403);
    chk_word(pc_out, 32'h0000_0800);
    // Write-backs above left carry and overflow set; later status checks expect clear flags
    run_op(OP_FLAGS, 4'h0, 6'h00, 32'h0);
    chk_word({28'h0, status_word[31:28]}, 32'h0);
  endtask

  task automatic t_mask();
    run_op(OP_CPSID, 4'h0, 6'h00, 32'h0);
    chk_bit(mask_out, 1'b1);
    exc_req = 1'b1;
    exc_num = EXC_SVC;
    @(negedge clk);
    chk_bit(exc_take, 1'b0);
    exc_num = EXC_NMI;
    @(negedge clk);
    chk_bit(exc_take, 1'b1);
    exc_num = EXC_HARD;
    @(negedge clk);
    chk_bit(exc_take, 1'b1);
    exc_req = 1'b0;
    run_op(OP_EXC_IN, 4'h0, EXC_SVC, 32'h0000_0201);
    chk_word(status_word, 32'h0100_0000);
    run_op(OP_CPSIE, 4'h0, 6'h00, 32'h0);
    chk_word(pc_out, 32'h0000_0808);
    chk_bit(mask_out, 1'b0);
    run_op(OP_MSR, 4'h1, 6'h00, 32'h0000_0001);
    chk_bit(mask_out, 1'b1);
    run_op(OP_MSR, 4'h1, 6'h00, 32'h0);
    chk_bit(mask_out, 1'b0);
  endtask

  task automatic t_exc();
    logic [5:0] codes [7];
    codes = '{EXC_NMI, EXC_HARD, EXC_SVC, EXC_PSV, EXC_TICK, EXC_IRQ0, EXC_IRQ_LAST};
    foreach (codes[i]) begin
      run_op(OP_EXC_IN, 4'h0, codes[i], 32'h0000_0201);
      chk_word(status_word, {26'h0040000, codes[i]});
      chk_word(lr_out, EXC_LINK_BASE);
      run_op(OP_EXC_OUT, 4'h0, 6'h00, 32'h0000_0301);
      chk_word(status_word, 32'h0100_0000);
    end
    run_op(OP_EXC_IN, 4'h0, EXC_PSV, 32'h0000_0201);
    run_op(OP_MSR, 4'h2, 6'h00, 32'h0000_0002);
    chk_bit(sp_sel_out, 1'b0);
    run_op(OP_EXC_OUT, 4'h0, 6'h00, 32'h0000_0301);
    run_op(OP_MSR, 4'h2, 6'h00, 32'h0000_0002);
    chk_bit(sp_sel_out, 1'b1);
    run_op(OP_WR, IDX_SP, 6'h00, 32'h2000_0F00);
    chk_word(psp_out, 32'h2000_0F00);
    chk_word(msp_out, SP_W);
    run_op(OP_EXC_IN, 4'h0, EXC_IRQ0, 32'h0000_0501);
    chk_word(lr_out, 32'hFFFF_FFF5);
    run_op(OP_WR, IDX_SP, 6'h00, 32'h2000_0E00);
    chk_word(msp_out, 32'h2000_0E00);
    chk_word(psp_out, 32'h2000_0F00);
    run_op(OP_EXC_OUT, 4'h0, 6'h00, 32'h0000_0601);
    chk_bit(sp_sel_out, 1'b1);
  endtask

  task automatic t_region();
    logic [31:0] adr [6];
    ccrs_rgn_e   rgn [6];
    adr = '{32'h0000_0000, 32'h3FFF_FFFC, 32'h4000_0000, 32'h6000_0000,
            32'hE00F_FFFC, 32'hE010_0000};
    rgn = '{RG_CODE, RG_SRAM, RG_PERI, RG_NONE, RG_PPB, RG_VEND};
    acc_valid = 1'b1;
    acc_fetch = 1'b1;
    foreach (adr[i]) begin
      acc_addr = adr[i];
      @(negedge clk);
      chk_word({29'h0, acc_region}, {29'h0, rgn[i]});
      chk_bit(acc_fault, i > 1);
    end
    acc_fetch = 1'b0;
    acc_addr = 32'h4000_0000;
    @(negedge clk);
    chk_bit(acc_fault, 1'b0);
    acc_valid = 1'b0;
  endtask

  // Clearing the state bit is only undone by reset, so this runs last
  task automatic t_fault();
    run_op(OP_BX, 4'h0, 6'h00, 32'h0000_0900);
    chk_word(status_word, 32'h0);
    run_op(OP_WR, 4'h1, 6'h00, 32'h0000_0005);
    chk_bit(fault_pulse, 1'b1);
    chk_bit(res_valid, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    op_valid = 1'b0;
    op = '0;
    exc_req = 1'b0;
    exc_num = 6'h00;
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_fetch = 1'b0;
    n_fail = 0;
    comparisons = 0;
    @(negedge clk);
    do_reset();
    t_boot();
    t_regs();
    t_mask();
    t_exc();
    t_region();
    t_fault();
    do_reset();
    t_boot();
    give_verdict();
  end
endmodule
`default_nettype wire
